// ---- oic_ctrl.sv ----
// internal oscillator control: registers, suspend, ready flags, source mux
// assumes oscillator outputs arrive as levels synchronous to clock
`timescale 1ns/1ns
`default_nettype none
// Operation
// - reset selects high-frequency oscillator as clock
// - 8-bit trim register, factory reset value
// - hf divider 00/01/10/11 is 8/4/2/1
// - suspend bit 5 stops hf oscillator, and the core when hf is the selected source
// - port 0-2 match or low comparator wakes
// - wake restarts oscillator, core and peripherals
// - core resumes after the suspending write
// - hf enable bit 7, enabled at reset
// - bit 6 ready only at programmed frequency
// - reserved bits 4:2 read zero, written zero
// - lf divider 00/01/10/11 is 8/4/2/1
// - lf fine tune bits 5:2, zero fastest
// - lf enable bit 7 off, ready bit 6
// - lf falling captures timer 2, rising timer 3
// - capture copies timer count into reload pair
// - clock from external, either internal, or pll
// - selector 000 hf, 001 ext, 010 lf, 100 pll
module oic_ctrl
    import oic_pkg::*;
#(
    parameter logic [7:0] HF_TRIM_RESET = 8'h80,
    parameter logic [3:0] LF_TUNE_RESET = 4'h8
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         resetn,
    // register port
    input  wire oic_sfr_req_t sfr_req,
    output var  logic [7:0]   sfr_rdata,
    // oscillator sources
    input  wire logic         hf_osc_in,
    input  wire logic         lf_osc_in,
    input  wire logic         ext_osc_in,
    input  wire logic         pll_clk_in,
    // oscillator controls
    output var  logic         hf_osc_run,
    output var  logic [7:0]   hf_trim_out,
    output var  logic         lf_osc_run,
    output var  logic [3:0]   lf_fine_tune,
    // wake events
    input  wire oic_wake_t    wake,
    // timer capture
    input  wire logic         timer2_lf_capture,
    input  wire logic         timer3_lf_capture,
    input  wire logic [15:0]  timer2_count,
    input  wire logic [15:0]  timer3_count,
    output var  logic         timer2_capture,
    output var  logic         timer3_capture,
    output var  logic [15:0]  timer2_reload,
    output var  logic [15:0]  timer3_reload,
    // system clock
    output var  logic         system_clock,
    output var  logic         core_clock_enable
);
    oic_hf_state_t hf_state_reg, hf_state_next;
    logic [OIC_SETTLE_W-1:0] hf_cnt_reg, hf_cnt_next;
    logic [OIC_SETTLE_W-1:0] lf_cnt_reg, lf_cnt_next;
    logic        hf_en_reg, hf_en_next;
    logic [1:0]  hf_div_reg, hf_div_next;
    logic [7:0]  trim_reg, trim_next;
    logic        lf_en_reg, lf_en_next;
    logic        lf_rdy_reg, lf_rdy_next;
    logic [3:0]  tune_reg, tune_next;
    logic [1:0]  lf_div_reg, lf_div_next;
    logic [2:0]  sel_reg, sel_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        system_clock_reg, system_clock_next;
    logic        core_en_reg, core_en_next;
    logic        lf_prev_reg, lf_prev_next;
    logic        cap2_reg, cap2_next;
    logic        cap3_reg, cap3_next;
    logic [15:0] rl2_reg, rl2_next;
    logic [15:0] rl3_reg, rl3_next;
    logic        hf_run_reg, hf_run_next;
    logic        wr_hf, wr_lf, wr_trim, wr_sel;
    logic        wake_any, hf_rdy;
    logic        hf_scaled, lf_scaled;

    assign wr_hf    = sfr_req.wr && sfr_req.addr == OIC_ADDR_HF_CTRL;
    assign wr_lf    = sfr_req.wr && sfr_req.addr == OIC_ADDR_LF_CTRL;
    assign wr_trim  = sfr_req.wr && sfr_req.addr == OIC_ADDR_HF_TRIM;
    assign wr_sel   = sfr_req.wr && sfr_req.addr == OIC_ADDR_SYS_SEL;
    assign wake_any = |wake.port_match ||
                      |(wake.cmp_enable & ~wake.cmp_out);
    assign hf_rdy   = hf_state_reg == OIC_HF_RUN;

    // post-scalers; they hold while their oscillator is stopped
    oic_clk_div u_hf_div (
        .clock   (clock),
        .resetn  (resetn),
        .src     (hf_osc_in && hf_run_reg),
        .sel     (hf_div_reg),
        .div_out (hf_scaled)
    );

    oic_clk_div u_lf_div (
        .clock   (clock),
        .resetn  (resetn),
        .src     (lf_osc_in && lf_en_reg),
        .sel     (lf_div_reg),
        .div_out (lf_scaled)
    );

    // high-frequency oscillator: enable, suspend and settling
    always_comb begin
        hf_en_next    = wr_hf ? sfr_req.wdata[OIC_HF_EN_BIT]
                              : hf_en_reg;
        hf_div_next   = wr_hf ? sfr_req.wdata[OIC_DIV_MSB:0] : hf_div_reg;
        trim_next     = wr_trim ? sfr_req.wdata : trim_reg;
        hf_state_next = hf_state_reg;
        hf_cnt_next   = hf_cnt_reg;
        case (hf_state_reg)
            OIC_HF_OFF: begin
                if (hf_en_reg) begin
                    hf_state_next = OIC_HF_SETTLE;
                    hf_cnt_next   = '0;
                end
            end
            OIC_HF_SETTLE, OIC_HF_RUN: begin
                if (hf_state_reg == OIC_HF_SETTLE) begin
                    hf_cnt_next = hf_cnt_reg + 1'b1;
                    if (hf_cnt_reg ==
                        OIC_SETTLE_W'(OIC_HF_SETTLE_CYC - 1)) begin
                        hf_state_next = OIC_HF_RUN;
                    end
                end
                // a new trim or ratio is not ready until it settles
                if (wr_trim || (wr_hf && hf_div_next != hf_div_reg)) begin
                    hf_state_next = OIC_HF_SETTLE;
                    hf_cnt_next   = '0;
                end
                // wake in the same cycle wins so a pulse is never lost
                if (wr_hf && sfr_req.wdata[OIC_HF_SUSP_BIT] && !wake_any) begin
                    hf_state_next = OIC_HF_SUSPENDED;
                end
                if (!hf_en_reg) begin
                    hf_state_next = OIC_HF_OFF;
                end
            end
            OIC_HF_SUSPENDED: begin
                if (wake_any) begin
                    hf_state_next = OIC_HF_SETTLE;
                    hf_cnt_next   = '0;
                end
            end
            default: begin
                hf_state_next = OIC_HF_OFF;
            end
        endcase
        hf_run_next = hf_en_reg && hf_state_next != OIC_HF_SUSPENDED;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            hf_state_reg <= OIC_HF_OFF;
            hf_cnt_reg   <= '0;
            hf_en_reg    <= OIC_HF_CTRL_RESET[OIC_HF_EN_BIT];
            hf_div_reg   <= OIC_DIV_RESET;
            trim_reg     <= HF_TRIM_RESET;
            hf_run_reg   <= 1'b0;
        end else begin
            hf_state_reg <= hf_state_next;
            hf_cnt_reg   <= hf_cnt_next;
            hf_en_reg    <= hf_en_next;
            hf_div_reg   <= hf_div_next;
            trim_reg     <= trim_next;
            hf_run_reg   <= hf_run_next;
        end
    end

    // low-frequency oscillator and timer capture
    always_comb begin
        lf_en_next   = wr_lf ? sfr_req.wdata[OIC_LF_EN_BIT]
                             : lf_en_reg;
        tune_next    = wr_lf ? sfr_req.wdata[OIC_LF_TUNE_MSB:OIC_LF_TUNE_LSB]
                             : tune_reg;
        lf_div_next  = wr_lf ? sfr_req.wdata[OIC_DIV_MSB:0] : lf_div_reg;
        lf_cnt_next  = lf_cnt_reg;
        lf_rdy_next  = lf_rdy_reg;
        if (!lf_en_reg || (wr_lf && tune_next != tune_reg)) begin
            lf_cnt_next = '0;
            lf_rdy_next = 1'b0;
        end else if (!lf_rdy_reg) begin
            lf_cnt_next = lf_cnt_reg + 1'b1;
            lf_rdy_next = lf_cnt_reg ==
                          OIC_SETTLE_W'(OIC_LF_SETTLE_CYC - 1);
        end
        lf_prev_next = lf_scaled;
        cap2_next    = timer2_lf_capture && lf_prev_reg && !lf_scaled;
        cap3_next    = timer3_lf_capture && !lf_prev_reg && lf_scaled;
        rl2_next     = cap2_next ? timer2_count : rl2_reg;
        rl3_next     = cap3_next ? timer3_count : rl3_reg;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            lf_en_reg   <= 1'b0;
            lf_rdy_reg  <= 1'b0;
            lf_cnt_reg  <= '0;
            tune_reg    <= LF_TUNE_RESET;
            lf_div_reg  <= OIC_DIV_RESET;
            lf_prev_reg <= 1'b0;
            cap2_reg    <= 1'b0;
            cap3_reg    <= 1'b0;
            rl2_reg     <= 16'h0000;
            rl3_reg     <= 16'h0000;
        end else begin
            lf_en_reg   <= lf_en_next;
            lf_rdy_reg  <= lf_rdy_next;
            lf_cnt_reg  <= lf_cnt_next;
            tune_reg    <= tune_next;
            lf_div_reg  <= lf_div_next;
            lf_prev_reg <= lf_prev_next;
            cap2_reg    <= cap2_next;
            cap3_reg    <= cap3_next;
            rl2_reg     <= rl2_next;
            rl3_reg     <= rl3_next;
        end
    end

    // source select, system clock and register reads
    always_comb begin
        sel_next = sel_reg;
        // reserved codes are refused so the clock never loses its source
        if (wr_sel) begin
            case (sfr_req.wdata[OIC_SEL_MSB:0])
                OIC_SRC_HF, OIC_SRC_EXT, OIC_SRC_LF, OIC_SRC_PLL: begin
                    sel_next = sfr_req.wdata[OIC_SEL_MSB:0];
                end
                default: begin
                    sel_next = sel_reg;
                end
            endcase
        end
        case (sel_reg)
            OIC_SRC_EXT: system_clock_next = ext_osc_in;
            OIC_SRC_LF:  system_clock_next = lf_scaled;
            OIC_SRC_PLL: system_clock_next = pll_clk_in;
            default:     system_clock_next = hf_scaled;
        endcase
        // core stalls while suspended with hf selected and resumes at the next instruction
        core_en_next = !(sel_reg == OIC_SRC_HF && !hf_run_reg);
        rdata_next   = 8'h00;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                OIC_ADDR_HF_CTRL: rdata_next = {hf_en_reg, hf_rdy,
                    hf_state_reg == OIC_HF_SUSPENDED, 3'h0, hf_div_reg};
                OIC_ADDR_LF_CTRL: rdata_next = {lf_en_reg, lf_rdy_reg,
                    tune_reg, lf_div_reg};
                OIC_ADDR_HF_TRIM: rdata_next = trim_reg;
                OIC_ADDR_SYS_SEL: rdata_next = {5'h00, sel_reg};
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            sel_reg     <= OIC_SEL_RESET;
            system_clock_reg  <= 1'b0;
            core_en_reg <= 1'b1;
            rdata_reg   <= 8'h00;
        end else begin
            sel_reg     <= sel_next;
            system_clock_reg  <= system_clock_next;
            core_en_reg <= core_en_next;
            rdata_reg   <= rdata_next;
        end
    end

    assign sfr_rdata         = rdata_reg;
    assign hf_osc_run        = hf_run_reg;
    assign hf_trim_out       = trim_reg;
    assign lf_osc_run        = lf_en_reg;
    assign lf_fine_tune      = tune_reg;
    assign timer2_capture    = cap2_reg;
    assign timer3_capture    = cap3_reg;
    assign timer2_reload     = rl2_reg;
    assign timer3_reload     = rl3_reg;
    assign system_clock      = system_clock_reg;
    assign core_clock_enable = core_en_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    reset_source_a: assert property (
        $rose(resetn) |-> sel_reg == OIC_SRC_HF)
        else $error("source not hf after reset");
    suspend_halt_a: assert property (
        (wr_hf && sfr_req.wdata[OIC_HF_SUSP_BIT] && hf_rdy && hf_en_reg
        && !wake_any) |=> !hf_run_reg)
        else $error("suspend write did not stop oscillator");
    wake_resume_a: assert property (
        (hf_state_reg == OIC_HF_SUSPENDED && wake_any && hf_en_reg)
        |=> hf_run_reg)
        else $error("wake did not restart oscillator");
    core_stall_a: assert property (
        (sel_reg == OIC_SRC_HF && !hf_run_reg) |=> !core_clock_enable)
        else $error("core clock not stopped");
    reserved_zero_a: assert property (
        (sfr_req.rd && sfr_req.addr == OIC_ADDR_HF_CTRL)
        |=> sfr_rdata[4:2] == 3'h0)
        else $error("reserved bits not zero");
    hf_ready_a: assert property (
        (hf_state_reg == OIC_HF_OFF) |-> ##1 (!hf_rdy)[*2])
        else $error("hf ready before settling");
    capture_copy_a: assert property (
        cap2_next |=> timer2_reload == $past(timer2_count) && timer2_capture)
        else $error("timer 2 capture did not copy count");
    lf_capture_edge_a: assert property (
        timer3_capture |-> $past(timer3_lf_capture) && $past(lf_scaled)
        && !$past(lf_prev_reg))
        else $error("timer 3 capture not on rising edge");
    select_reserved_a: assert property (
        (wr_sel && sfr_req.wdata[OIC_SEL_MSB:0] == 3'h3) |=> $stable(sel_reg))
        else $error("reserved source code taken");

    suspend_wake_c: cover property (hf_state_reg == OIC_HF_SUSPENDED
        ##[1:50] hf_run_reg);
    lf_ready_c: cover property ($rose(lf_rdy_reg));
    capture_pair_c: cover property (timer2_capture ##[1:1000] timer3_capture);

endmodule // oic_ctrl
`default_nettype wire

// ---- oic_pkg.sv ----
// internal oscillator control: shared constants, register map and carriers
// assumes one 125 MHz clock; the core drives the register port directly
`default_nettype none
package oic_pkg;

    // register port addresses
    localparam logic [7:0] OIC_ADDR_LF_CTRL  = 8'had;
    localparam logic [7:0] OIC_ADDR_HF_CTRL  = 8'hb7;
    localparam logic [7:0] OIC_ADDR_HF_TRIM  = 8'hbf;
    localparam logic [7:0] OIC_ADDR_SYS_SEL  = 8'h8f;

    // hf_osc_control field positions
    localparam int OIC_HF_EN_BIT      = 7;
    localparam int OIC_HF_RDY_BIT     = 6;
    localparam int OIC_HF_SUSP_BIT    = 5;
    localparam int OIC_DIV_MSB        = 1;
    // lf_osc_control and source select field positions
    localparam int OIC_LF_EN_BIT      = 7;
    localparam int OIC_LF_RDY_BIT     = 6;
    localparam int OIC_LF_TUNE_MSB    = 5;
    localparam int OIC_LF_TUNE_LSB    = 2;
    localparam int OIC_SEL_MSB        = 2;

    // reset values
    localparam logic [7:0] OIC_HF_CTRL_RESET = 8'hc0;
    localparam logic [1:0] OIC_DIV_RESET     = 2'h0;
    localparam logic [2:0] OIC_SEL_RESET     = 3'h0;

    // system clock source codes
    localparam logic [2:0] OIC_SRC_HF  = 3'h0;
    localparam logic [2:0] OIC_SRC_EXT = 3'h1;
    localparam logic [2:0] OIC_SRC_LF  = 3'h2;
    localparam logic [2:0] OIC_SRC_PLL = 3'h4;

    // settling times
    localparam int OIC_CLK_PERIOD_NS = 8;
    localparam int OIC_HF_SETTLE_NS  = 1000;
    localparam int OIC_LF_SETTLE_NS  = 20000;
    localparam int OIC_HF_SETTLE_CYC =
        (OIC_HF_SETTLE_NS + OIC_CLK_PERIOD_NS - 1) / OIC_CLK_PERIOD_NS;
    localparam int OIC_LF_SETTLE_CYC =
        (OIC_LF_SETTLE_NS + OIC_CLK_PERIOD_NS - 1) / OIC_CLK_PERIOD_NS;
    localparam int OIC_SETTLE_W      = 12;

    typedef enum logic [1:0] {
        OIC_HF_OFF,
        OIC_HF_SETTLE,
        OIC_HF_RUN,
        OIC_HF_SUSPENDED
    } oic_hf_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } oic_sfr_req_t;

    typedef struct packed {
        logic [2:0] port_match;
        logic [1:0] cmp_enable;
        logic [1:0] cmp_out;
    } oic_wake_t;

endpackage
`default_nettype wire

// ---- oic_clk_div.sv ----
// internal oscillator control: glitch-free post-scaler for a sampled clock
// assumes src is a level sampled on clock, much slower than clock
`timescale 1ns/1ns
`default_nettype none
module oic_clk_div
    import oic_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // source and ratio
    input  wire logic       src,
    input  wire logic [1:0] sel,
    // divided level
    output var  logic       div_out
);
    logic       src_prev_reg, src_prev_next;
    logic       out_reg, out_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [1:0] ratio_reg, ratio_next;
    logic [2:0] half_last;

    // 00 -> 8, 01 -> 4, 10 -> 2, 11 -> 1; one half period = ratio src edges
    always_comb begin
        half_last     = 3'((4'h8 >> ratio_reg) - 4'h1);
        src_prev_next = src;
        out_next      = out_reg;
        cnt_next      = cnt_reg;
        ratio_next    = ratio_reg;
        if (src != src_prev_reg) begin
            if (cnt_reg == half_last) begin
                cnt_next = 3'h0;
                out_next = !out_reg;
                // ratio only changes at a full period boundary
                if (!out_reg) begin
                    ratio_next = sel;
                end
            end else begin
                cnt_next = cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            src_prev_reg <= 1'b0;
            out_reg      <= 1'b0;
            cnt_reg      <= 3'h0;
            ratio_reg    <= OIC_DIV_RESET;
        end else begin
            src_prev_reg <= src_prev_next;
            out_reg      <= out_next;
            cnt_reg      <= cnt_next;
            ratio_reg    <= ratio_next;
        end
    end

    assign div_out = out_reg;

    ratio_hold_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (ratio_reg != $past(ratio_reg)) |-> out_reg)
        else $error("divider ratio changed mid period");

endmodule // oic_clk_div
`default_nettype wire

// ---- oic_osc_model.sv ----
// internal oscillator control: behavioural oscillators at the far side
// assumes the bench clock; outputs change on the falling edge only
`timescale 1ns/1ns
`default_nettype none
module oic_osc_model #(
    parameter int HF_HALF  = 4,
    parameter int LF_HALF  = 2,
    parameter int EXT_HALF = 3
) (
    // clock
    input  wire logic clock,
    // run controls from the block
    input  wire logic hf_run,
    input  wire logic lf_run,
    // oscillator levels
    output var  logic hf_out,
    output var  logic lf_out,
    output var  logic ext_out,
    output var  logic pll_out
);
    int   hf_cnt  = 0;
    int   lf_cnt  = 0;
    int   ext_cnt = 0;
    logic hf_q    = 1'b0;
    logic lf_q    = 1'b0;
    logic ext_q   = 1'b0;
    logic pll_q   = 1'b0;

    // a stopped oscillator freezes its level, as a real one would
    always @(negedge clock) begin
        if (hf_run === 1'b1) begin
            hf_cnt = (hf_cnt + 1) % HF_HALF;
            if (hf_cnt == 0) hf_q <= ~hf_q;
        end
        if (lf_run === 1'b1) begin
            lf_cnt = (lf_cnt + 1) % LF_HALF;
            if (lf_cnt == 0) lf_q <= ~lf_q;
        end
        ext_cnt = (ext_cnt + 1) % EXT_HALF;
        if (ext_cnt == 0) ext_q <= ~ext_q;
        pll_q <= ~pll_q;
    end

    assign hf_out  = hf_q;
    assign lf_out  = lf_q;
    assign ext_out = ext_q;
    assign pll_out = pll_q;
endmodule // oic_osc_model
`default_nettype wire

// ---- oic_tb.sv ----
// internal oscillator control: self-checking bench for oic_ctrl
// assumes oic_osc_model stands in for the oscillators
`timescale 1ns/1ns
`default_nettype none
module tb;
    import oic_pkg::*;
    logic         clock;
    logic         resetn;
    oic_sfr_req_t sfr_req;
    logic [7:0]   sfr_rdata;
    logic         hf_in, lf_in, ext_in, pll_in;
    logic         hf_run, lf_run;
    logic [7:0]   trim;
    logic [3:0]   tune;
    oic_wake_t    wake;
    logic         t2_mode, t3_mode, t2_cap, t3_cap;
    logic [15:0]  t2_rel, t3_rel;
    logic [15:0]  tcount = 16'h0000;
    logic         system_clock, core_clock_enable;
    int           err_count, compares, per;
    logic [7:0]   rv;

    oic_ctrl i_dut (.clock(clock), .resetn(resetn), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .hf_osc_in(hf_in), .lf_osc_in(lf_in),
        .ext_osc_in(ext_in), .pll_clk_in(pll_in), .hf_osc_run(hf_run),
        .hf_trim_out(trim), .lf_osc_run(lf_run), .lf_fine_tune(tune),
        .wake(wake), .timer2_lf_capture(t2_mode),
        .timer3_lf_capture(t3_mode), .timer2_count(tcount),
        .timer3_count(tcount), .timer2_capture(t2_cap),
        .timer3_capture(t3_cap), .timer2_reload(t2_rel),
        .timer3_reload(t3_rel), .system_clock(system_clock),
        .core_clock_enable(core_clock_enable));

    oic_osc_model i_osc (.clock(clock), .hf_run(hf_run), .lf_run(lf_run),
        .hf_out(hf_in), .lf_out(lf_in), .ext_out(ext_in), .pll_out(pll_in));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(negedge clock) tcount <= tcount + 16'h1;

    task automatic stop_test;
        if (err_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clock);
        sfr_req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clock);
        sfr_req.rd <= 1'b0;
        rv = sfr_rdata;
        check({8'h00, rv}, {8'h00, e});
    endtask

    // cycles between rises of system_clock, skipping the first two periods
    task automatic measure(output int p);
        logic prev;
        for (int k = 0; k < 3; k++) begin
            p = 1;
            @(negedge clock);
            prev = system_clock;
            while (!(system_clock === 1'b1 && prev === 1'b0) && p < 300) begin
                prev = system_clock;
                @(negedge clock);
                p++;
            end
        end
    endtask

    // first capture after a ratio change may be short, so diff the last two
    task automatic cap(input logic sel3, input int exp);
        logic [15:0] a, b;
        int n;
        b = 16'h0;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(negedge clock);
                n++;
            end while ((sel3 ? t3_cap : t2_cap) !== 1'b1 && n < 300);
            a = b;
            b = sel3 ? t3_rel : t2_rel;
            // reload holds the count of this cycle; tcount steps after us
            check(b, tcount);
        end
        check(b - a, exp[15:0]);
    endtask

    initial begin
        err_count = 0;
        compares = 0;
        repeat (60000) @(posedge clock);
        err_count++;
        stop_test;
    end

    initial begin
        sfr_req = '0;
        wake = '{port_match: 3'h0, cmp_enable: 2'h0, cmp_out: 2'h3};
        t2_mode = 1'b0;
        t3_mode = 1'b0;
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        repeat (140) @(negedge clock);
        check({14'h0, hf_run, lf_run}, 16'h2);
        rd_chk(OIC_ADDR_HF_CTRL, 8'hc0);
        rd_chk(OIC_ADDR_HF_TRIM, 8'h80);
        rd_chk(OIC_ADDR_LF_CTRL, 8'h20);
        rd_chk(OIC_ADDR_SYS_SEL, 8'h00);
        rd_chk(8'h00, 8'h00);
        wr(OIC_ADDR_HF_CTRL, 8'h83);
        rd_chk(OIC_ADDR_HF_CTRL, 8'h83);
        repeat (140) @(negedge clock);
        rd_chk(OIC_ADDR_HF_CTRL, 8'hc3);
        for (int c = 0; c < 4; c++) begin
            wr(OIC_ADDR_HF_CTRL, 8'h80 | 8'(c));
            measure(per);
            check(16'(per), 16'(8 * (8 >> c)));
        end
        wr(OIC_ADDR_HF_TRIM, 8'h5a);
        check({8'h0, trim}, 16'h5a);
        rd_chk(OIC_ADDR_HF_TRIM, 8'h5a);
        wr(OIC_ADDR_LF_CTRL, 8'hbf);
        check({11'h0, lf_run, tune}, 16'h1f);
        wr(OIC_ADDR_SYS_SEL, 8'h02);
        measure(per);
        check(16'(per), 16'd4);
        wr(OIC_ADDR_SYS_SEL, 8'h01);
        measure(per);
        check(16'(per), 16'd6);
        wr(OIC_ADDR_SYS_SEL, 8'h04);
        measure(per);
        check(16'(per), 16'd2);
        wr(OIC_ADDR_SYS_SEL, 8'h03);
        rd_chk(OIC_ADDR_SYS_SEL, 8'h04);
        repeat (2600) @(negedge clock);
        rd_chk(OIC_ADDR_LF_CTRL, 8'hff);
        wr(OIC_ADDR_SYS_SEL, 8'h00);
        t2_mode = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(OIC_ADDR_LF_CTRL, 8'hbc | 8'(c));
            cap(1'b0, 4 * (8 >> c));
        end
        check(t3_rel, 16'h0);
        t2_mode = 1'b0;
        t3_mode = 1'b1;
        cap(1'b1, 4);
        t3_mode = 1'b0;
        for (int w = 0; w < 5; w++) begin
            wr(OIC_ADDR_HF_CTRL, 8'ha3);
            repeat (3) @(negedge clock);
            check({14'h0, hf_run, core_clock_enable}, 16'h0);
            rd_chk(OIC_ADDR_HF_CTRL, 8'ha3);
            wake.cmp_enable = 2'h3;
            repeat (3) @(negedge clock);
            check({15'h0, hf_run}, 16'h0);
            if (w < 3) wake.port_match[w] = 1'b1;
            else wake.cmp_out[w-3] = 1'b0;
            @(negedge clock);
            wake = '{port_match: 3'h0, cmp_enable: 2'h0, cmp_out: 2'h3};
            repeat (3) @(negedge clock);
            check({14'h0, hf_run, core_clock_enable}, 16'h3);
            rd_chk(OIC_ADDR_HF_TRIM, 8'h5a);
        end
        stop_test;
    end
endmodule // tb
`default_nettype wire
